/* File: logic/wdt_pkg.sv */
/*
 Constants for the watchdog timeout and interrupt routing block.
 Assumes a 32-bit AHB-Lite register bus and a 16-line interrupt request vector.
*/
package wdt_pkg;
   localparam int unsigned       DATA_W        = 32;
   localparam int unsigned       ADDR_W        = 32;
   localparam int unsigned       CNT_W         = 27;
   localparam int unsigned       EXP_W         = 5;
   localparam int unsigned       IRQ_LINES     = 16;
   // Register byte offsets
   localparam logic [7:0]        CFG_OFFSET    = 8'h00;
   localparam logic [7:0]        STATUS_OFFSET = 8'h04;
   localparam logic [7:0]        COUNT_OFFSET  = 8'h08;
   // Configuration field layout
   localparam int unsigned       COUNT_LSB     = 0;
   localparam int unsigned       COUNT_W       = 8;
   localparam int unsigned       ROUTE_LSB     = 8;
   localparam int unsigned       ROUTE_W       = 4;
   localparam int unsigned       FLAG_BIT      = 0;
   // Reset values
   localparam logic [7:0]        COUNT_RESET   = 8'h00;
   localparam logic [3:0]        ROUTE_RESET   = 4'h0;
   // Timeout exponents per lowest set count bit
   localparam logic [EXP_W-1:0]  EXP_BIT0      = 5'h0A;
   localparam logic [EXP_W-1:0]  EXP_BIT1      = 5'h14;
   localparam logic [EXP_W-1:0]  EXP_BIT2      = 5'h15;
   // Routing codes and their request lines
   localparam logic [3:0]        ROUTE_OFF     = 4'h0;
   localparam logic [3:0]        ROUTE_IRQ9    = 4'h1;
   localparam logic [3:0]        ROUTE_IRQ3    = 4'h2;
   localparam logic [3:0]        ROUTE_IRQ10   = 4'h3;
   localparam logic [3:0]        ROUTE_IRQ4    = 4'h4;
   localparam logic [3:0]        ROUTE_IRQ5    = 4'h5;
   localparam logic [3:0]        ROUTE_IRQ6    = 4'h6;
   localparam logic [3:0]        ROUTE_IRQ14   = 4'hD;
   localparam logic [3:0]        ROUTE_IRQ15   = 4'hF;
   // AHB transfer types
   localparam logic [1:0]        HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]        HTRANS_SEQ    = 2'h3;
endpackage

/* File: logic/route_if.sv */
/*
 Carrier between the watchdog core and its routing decoder.
 Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface route_if;
   logic [3:0]  code;
   logic        irq;
   logic [15:0] lines;
   modport core (output code, output irq, input lines);
   modport dec  (input code, input irq, output lines);
endinterface

/* File: logic/irq_route_decode.sv */
/*
 Decodes the routing code and drives the selected request line from a flip-flop.
 Assumes the core holds code and irq as registered levels.
*/
`timescale 1ns/1ps
module irq_route_decode
   import wdt_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Core side
   route_if.dec      rt
);
   logic [IRQ_LINES-1:0] lines_d;
   logic [IRQ_LINES-1:0] lines_q;

   always_comb begin
      lines_d = '0;
      unique case (rt.code)
         ROUTE_IRQ9:  lines_d[9]  = rt.irq;
         ROUTE_IRQ3:  lines_d[3]  = rt.irq;
         ROUTE_IRQ10: lines_d[10] = rt.irq;
         ROUTE_IRQ4:  lines_d[4]  = rt.irq;
         ROUTE_IRQ5:  lines_d[5]  = rt.irq;
         ROUTE_IRQ6:  lines_d[6]  = rt.irq;
         ROUTE_IRQ14: lines_d[14] = rt.irq;
         ROUTE_IRQ15: lines_d[15] = rt.irq;
         // Disable and reserved codes drive nothing
         default:     lines_d     = '0;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lines_q <= '0;
      end else begin
         lines_q <= lines_d;
      end
   end

   assign rt.lines = lines_q;
endmodule

/* File: logic/watchdog_route_timeout.sv */
/*
 Watchdog timeout length selection and interrupt routing, with an AHB-Lite slave.
 Assumes timer ticks arrive as one-cycle enable pulses synchronous to clk.
*/
// What this block does
// - Four-bit field in bits 11:8 picks the interrupt line; zero disables routing.
// - Codes 1,2,3,4 give lines 9,3,10,4; codes 5,6,13,15 give 5,6,14,15; other codes none.
// - Timeout after two to the exponent timer periods, exponent from bits 7:0.
// - Lowest set count bit: bit0 10, bit1 20, bits2-7 21-26; zero none.
`timescale 1ns/1ps
module watchdog_route_timeout
   import wdt_pkg::*;
(
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      resetn,
   // AHB-Lite slave
   input  wire logic                      hsel,
   input  wire logic [wdt_pkg::ADDR_W-1:0] haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [wdt_pkg::DATA_W-1:0] hwdata,
   input  wire logic                      hready,
   output logic      [wdt_pkg::DATA_W-1:0] hrdata,
   output logic                           hreadyout,
   output logic                           hresp,
   // Timer clock ticks and selection
   input  wire logic                      tick_internal,
   input  wire logic                      tick_alternate,
   input  wire logic                      tick_select,
   // Interrupt request lines
   output logic      [wdt_pkg::IRQ_LINES-1:0] irq_req
);
   import wdt_pkg::*;

   route_if rt ();

   logic [COUNT_W-1:0] timeout_count_select_q;
   logic [ROUTE_W-1:0] irq_route_select_q;
   logic               flag_q;
   logic [CNT_W-1:0]   cnt_q;
   logic [DATA_W-1:0]  hrdata_q;
   logic               wr_pend_q;
   logic [7:0]         wr_addr_q;
   logic               access;
   logic               cfg_wr;
   logic               flag_clr;
   logic               tick;
   logic [EXP_W-1:0]   exp_sel;
   logic [CNT_W-1:0]   limit;
   logic               timeout;
   logic [DATA_W-1:0]  rd_d;

   function automatic logic [EXP_W-1:0] exp_of(input logic [COUNT_W-1:0] c);
      logic [EXP_W-1:0] e;
      e = '0;
      for (int i = COUNT_W - 1; i >= 2; i--) begin
         if (c[i]) begin
            e = EXP_BIT2 + EXP_W'(i - 2);
         end
      end
      if (c[1]) begin
         e = EXP_BIT1;
      end
      if (c[0]) begin
         e = EXP_BIT0;
      end
      return e;
   endfunction

   // Bus address phase
   assign access    = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
   assign cfg_wr    = wr_pend_q && (wr_addr_q == CFG_OFFSET);
   assign flag_clr  = wr_pend_q && (wr_addr_q == STATUS_OFFSET) && hwdata[FLAG_BIT];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= access && hwrite;
         wr_addr_q <= haddr[7:0];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         timeout_count_select_q <= COUNT_RESET;
         irq_route_select_q     <= ROUTE_RESET;
      end else if (cfg_wr) begin
         timeout_count_select_q <= hwdata[COUNT_LSB +: COUNT_W];
         irq_route_select_q     <= hwdata[ROUTE_LSB +: ROUTE_W];
      end
   end

   always_comb begin
      rd_d = '0;
      unique case (haddr[7:0])
         CFG_OFFSET: begin
            rd_d[COUNT_LSB +: COUNT_W] = timeout_count_select_q;
            rd_d[ROUTE_LSB +: ROUTE_W] = irq_route_select_q;
         end
         STATUS_OFFSET: rd_d[FLAG_BIT] = flag_q;
         COUNT_OFFSET:  rd_d[CNT_W-1:0] = cnt_q;
         default:       rd_d = '0;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hrdata_q <= '0;
      end else if (access && !hwrite) begin
         hrdata_q <= rd_d;
      end
   end

   assign tick    = tick_select ? tick_alternate : tick_internal;
   assign exp_sel = exp_of(timeout_count_select_q);
   assign limit   = CNT_W'((CNT_W'(1) << exp_sel) - CNT_W'(1));
   assign timeout = tick && (timeout_count_select_q != '0) && (cnt_q == limit);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= '0;
      end else if (cfg_wr || timeout_count_select_q == '0) begin
         cnt_q <= '0;
      end else if (tick) begin
         cnt_q <= timeout ? '0 : CNT_W'(cnt_q + CNT_W'(1));
      end
   end

   // Sticky flag, a new timeout beats the clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flag_q <= 1'b0;
      end else if (timeout) begin
         flag_q <= 1'b1;
      end else if (flag_clr) begin
         flag_q <= 1'b0;
      end
   end

   assign rt.code = irq_route_select_q;
   assign rt.irq  = flag_q;
   assign irq_req = rt.lines;

   irq_route_decode u_decode (
      .clk    (clk),
      .resetn (resetn),
      .rt     (rt)
   );
endmodule

/* File: dv/wdt_dv_pkg.sv */
/* Expected request line per routing code (16 = none).
 Assumes nothing of its surroundings. */
package wdt_dv_pkg;
   localparam logic [4:0] LINE_OF [16] = '{5'h10, 5'h09, 5'h03, 5'h0A, 5'h04, 5'h05, 5'h06,
      5'h10, 5'h10, 5'h10, 5'h10, 5'h10, 5'h10, 5'h0E, 5'h10, 5'h0F};
   function automatic logic [15:0] line_mask(input logic [3:0] c);
      return LINE_OF[c][4] ? 16'h0000 : 16'h0001 << LINE_OF[c];
   endfunction
endpackage

/* File: dv/irq_sink.sv */
/* Interrupt controller inputs: reports the raised request line.
 Assumes level requests, at most one line high. */
`timescale 1ns/1ps
module irq_sink (
   input  wire logic [15:0] irq_req,
   output logic      [4:0]  line
);
   always_comb begin
      line = 5'h10;
      for (int i = 0; i < 16; i++)
         if (irq_req[i]) line = 5'(i);
   end
endmodule

/* File: dv/wdt_asserts.sv */
/* Checker for watchdog_route_timeout.
 Sees only the top ports; bound at the foot. */
`timescale 1ns/1ps
module wdt_asserts
   import wdt_pkg::*;
   import wdt_dv_pkg::*;
(
   input wire logic        clk, resetn, hsel, hready, hwrite,
   input wire logic [31:0] haddr, hwdata,
   input wire logic [1:0]  htrans,
   input wire logic        tick_internal, tick_alternate, tick_select,
   input wire logic [15:0] irq_req
);
   logic        wr_q;
   logic [11:0] cfg_q;
   logic [9:0]  cnt_q;
   wire         tsel = tick_select ? tick_alternate : tick_internal;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Shadow configuration and ticks counted since its last write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_q  <= 1'b0;
         cfg_q <= 12'h000;
         cnt_q <= 10'h000;
      end else begin
         wr_q <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == CFG_OFFSET;
         if (wr_q) cfg_q <= hwdata[11:0];
         if (wr_q) cnt_q <= 10'h000;
         else if (tsel && cfg_q[7:0] != 8'h00) cnt_q <= cnt_q + 10'h001;
      end
   end
   chk_single_line: assert property ($onehot0(irq_req))
      else $error("two request lines high");
   chk_route_match: assert property (|irq_req |->
      irq_req == $past(line_mask(cfg_q[11:8]))) else $error("request on wrong line");
   chk_tick_cause: assert property ($rose(|irq_req) |-> $past(tsel, 2))
      else $error("timeout without a selected tick");
   chk_exact_count: assert property ($rose(|irq_req) && $past(cfg_q[0], 2)
      |-> $past(cnt_q, 2) == 10'h3FF) else $error("timeout not after 1024 ticks");
   chk_zero_count: assert property ($rose(|irq_req) |-> $past(cfg_q[7:0], 2) != 8'h00)
      else $error("timeout with count field zero");
   cover property ($rose(|irq_req));
   cover property (wr_q && hwdata[11:8] == 4'hF);
   cover property (tick_select && tick_alternate);
endmodule

bind watchdog_route_timeout wdt_asserts chk (.clk, .resetn, .hsel, .hready, .hwrite, .haddr,
   .hwdata, .htrans, .tick_internal, .tick_alternate, .tick_select, .irq_req);

/* File: dv/watchdog_route_timeout_tb_top.sv */
/* Bench: AHB-Lite master, timer ticks, irq_sink on the request lines.
 Assumes one slave, so hready is the slave's hreadyout. */
`timescale 1ns/1ps
module watchdog_route_timeout_tb_top;
   import wdt_pkg::*;
   import wdt_dv_pkg::*;
   logic        clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
   logic        t_int = 1'b0, t_alt = 1'b0, t_sel = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
   logic [1:0]  htrans = 2'h0;
   logic [15:0] irq_req;
   logic [4:0]  line;
   int          fails = 0, checked = 0;
   watchdog_route_timeout uut (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tick_internal(t_int),
      .tick_alternate(t_alt), .tick_select(t_sel), .irq_req);
   irq_sink sink (.irq_req, .line);
   task automatic stop_test();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // Single word transfer; read data lands in q
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h000000, a};
      hwrite <= w;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 20);
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 20);
      q = hrdata;
      cmp("hresp", 32'h0, {31'h0, hresp});
      if (n >= 20) begin fails++; stop_test(); end
   endtask
   task automatic ticks(input int n, input logic alt);
      repeat (n) begin
         t_int <= !alt;
         t_alt <= alt;
         @(posedge clk);
      end
      t_int <= 1'b0;
      t_alt <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic test_routes();
      xfer(1'b0, CFG_OFFSET, 32'h0);
      cmp("cfg reset", 32'h0, q);
      for (int c = 0; c < 16; c++) begin
         if (c != 0 && LINE_OF[c][4]) continue;
         xfer(1'b1, CFG_OFFSET, {20'h0, c[3:0], 8'h01});
         ticks(1023, 1'b0);
         cmp("irq early", 32'h0, {16'h0, irq_req});
         ticks(1, 1'b0);
         cmp("irq", {16'h0, line_mask(c[3:0])}, {16'h0, irq_req});
         cmp("line", {27'h0, LINE_OF[c]}, {27'h0, line});
         xfer(1'b1, STATUS_OFFSET, 32'h1);
      end
      $display("test_routes done");
   endtask
   task automatic test_exponent();
      xfer(1'b1, CFG_OFFSET, 32'h106);
      xfer(1'b0, CFG_OFFSET, 32'h0);
      cmp("cfg", 32'h106, q);
      ticks(1024, 1'b0);
      xfer(1'b0, COUNT_OFFSET, 32'h0);
      cmp("count", 32'h400, q);
      cmp("irq", 32'h0, {16'h0, irq_req});
      xfer(1'b1, CFG_OFFSET, 32'h100);
      ticks(8, 1'b0);
      xfer(1'b0, COUNT_OFFSET, 32'h0);
      cmp("count zero", 32'h0, q);
      xfer(1'b0, 8'h40, 32'h0);
      cmp("unmapped", 32'h0, q);
      $display("test_exponent done");
   endtask
   task automatic test_select();
      t_sel <= 1'b1;
      xfer(1'b1, CFG_OFFSET, 32'h101);
      ticks(1024, 1'b0);
      cmp("irq other", 32'h0, {16'h0, irq_req});
      ticks(1024, 1'b1);
      cmp("irq alt", 32'h200, {16'h0, irq_req});
      xfer(1'b1, STATUS_OFFSET, 32'h1);
      t_sel <= 1'b0;
      $display("test_select done");
   endtask
   initial begin
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      test_routes();
      test_exponent();
      test_select();
      stop_test();
   end
endmodule
